// ---- core/bcad_pkg.sv ----
package bcad_pkg;

  // Byte address of the bridge control word on the register bus.
  localparam logic [31:0] BCAD_CTRL_ADDR = 32'h0000_003C;

  // Field positions inside the bridge control word.
  localparam int BCAD_MA_MODE_BIT = 21;
  localparam int BCAD_SEC_RST_BIT = 22;
  localparam int BCAD_FB2B_BIT = 23;
  localparam int BCAD_PRI_LEN_BIT = 24;
  localparam int BCAD_SEC_LEN_BIT = 25;
  localparam int BCAD_TMO_STAT_BIT = 26;
  localparam int BCAD_TMO_SERR_BIT = 27;

  // Byte lanes that carry the implemented fields.
  localparam int BCAD_LANE_LO = 2;
  localparam int BCAD_LANE_HI = 3;

  // Data returned for a hidden master abort on a read.
  localparam logic [31:0] BCAD_ALL_ONES = 32'hFFFF_FFFF;

  // Discard timer lengths in PCI clock cycles, as powers of two.
  localparam int BCAD_LONG_LOG2 = 15;
  localparam int BCAD_SHORT_LOG2 = 10;
  localparam int unsigned BCAD_LONG_CYCLES = 32'h1 << BCAD_LONG_LOG2;
  localparam int unsigned BCAD_SHORT_CYCLES = 32'h1 << BCAD_SHORT_LOG2;
  localparam int BCAD_TMR_W = 16;

  // AXI response codes.
  localparam logic [1:0] BCAD_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCAD_RESP_SLVERR = 2'h2;

  // Delayed transaction events from one bus side.
  typedef struct packed {
    logic queued;
    logic repeated;
  } bcad_dt_evt_t;

  // Master abort seen on the secondary bus.
  typedef struct packed {
    logic valid;
    logic is_read;
    logic ta_possible;
  } bcad_ma_evt_t;

  // Software visible control and status fields.
  typedef struct packed {
    logic ma_mode;
    logic sec_rst;
    logic fb2b;
    logic pri_short;
    logic sec_short;
    logic tmo_stat;
    logic tmo_serr;
  } bcad_ctrl_t;

  // State of one discard timer.
  typedef struct packed {
    logic running;
    logic [BCAD_TMR_W-1:0] count;
    logic expire;
  } bcad_tmr_t;

  // State of the top module.
  typedef struct packed {
    bcad_ctrl_t ctrl;
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic serr;
    logic pri_discard;
    logic sec_discard;
    logic ma_read_ones;
    logic ma_write_drop;
    logic ma_target_abort;
    logic [31:0] ma_read_data;
  } bcad_top_t;

  localparam bcad_top_t BCAD_TOP_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// ---- core/bcad_discard_timer.sv ----
`timescale 1ns/1ps
// Counts down one discard period after a delayed completion is queued.
module bcad_discard_timer #(
  parameter int unsigned LONG_CYCLES = bcad_pkg::BCAD_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = bcad_pkg::BCAD_SHORT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic short_sel,
  input wire logic start,
  input wire logic stop,
  output logic expire
);

  localparam logic [bcad_pkg::BCAD_TMR_W-1:0] LONG_LOAD = bcad_pkg::BCAD_TMR_W'(LONG_CYCLES - 1);
  localparam logic [bcad_pkg::BCAD_TMR_W-1:0] SHORT_LOAD = bcad_pkg::BCAD_TMR_W'(SHORT_CYCLES - 1);

  bcad_pkg::bcad_tmr_t q;
  bcad_pkg::bcad_tmr_t d;

  // Start reloads, a repeated request stops, and reaching zero expires.
  always_comb begin
    d = q;
    d.expire = 1'b0;
    if (start) begin
      d.running = 1'b1;
      d.count = short_sel ? SHORT_LOAD : LONG_LOAD;
    end else if (stop) begin
      d.running = 1'b0;
    end else if (q.running) begin
      if (q.count == '0) begin
        d.running = 1'b0;
        d.expire = 1'b1;
      end else begin
        d.count = q.count - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expire = q.expire;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tmr_reload: assert property (start |=> q.running && q.count == ($past(short_sel) ? SHORT_LOAD : LONG_LOAD))
    else $error("Discard timer did not load the selected length.");

  chk_tmr_expire: assert property (q.running && q.count == '0 && !start && !stop |=> expire ##1 !expire)
    else $error("Discard timer did not expire once at zero.");

endmodule

// ---- core/bcad_top.sv ----
`timescale 1ns/1ps
module bcad_top #(
  parameter int unsigned LONG_CYCLES = bcad_pkg::BCAD_LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = bcad_pkg::BCAD_SHORT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire bcad_pkg::bcad_dt_evt_t pri_dt,
  input wire bcad_pkg::bcad_dt_evt_t sec_dt,
  input wire bcad_pkg::bcad_ma_evt_t ma,
  input wire logic serr_enable,
  output logic primary_system_error_out,
  output logic sec_reset_force,
  output logic fast_b2b_allow,
  output logic pri_discard,
  output logic sec_discard,
  output logic ma_read_ones,
  output logic ma_write_drop,
  output logic ma_target_abort,
  output logic [31:0] ma_read_data
);

  bcad_pkg::bcad_top_t q;
  bcad_pkg::bcad_top_t d;
  logic pri_exp;
  logic sec_exp;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] ctrl_word;

  // One discard timer per bus side.
  bcad_discard_timer #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_pri_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .short_sel(q.ctrl.pri_short),
    .start(pri_dt.queued),
    .stop(pri_dt.repeated),
    .expire(pri_exp)
  );

  bcad_discard_timer #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_sec_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .short_sel(q.ctrl.sec_short),
    .start(sec_dt.queued),
    .stop(sec_dt.repeated),
    .expire(sec_exp)
  );

  // Read view of the control word; unimplemented and reserved bits are zero.
  always_comb begin
    ctrl_word = '0;
    ctrl_word[bcad_pkg::BCAD_MA_MODE_BIT] = q.ctrl.ma_mode;
    ctrl_word[bcad_pkg::BCAD_SEC_RST_BIT] = q.ctrl.sec_rst;
    ctrl_word[bcad_pkg::BCAD_FB2B_BIT] = q.ctrl.fb2b;
    ctrl_word[bcad_pkg::BCAD_PRI_LEN_BIT] = q.ctrl.pri_short;
    ctrl_word[bcad_pkg::BCAD_SEC_LEN_BIT] = q.ctrl.sec_short;
    ctrl_word[bcad_pkg::BCAD_TMO_STAT_BIT] = q.ctrl.tmo_stat;
    ctrl_word[bcad_pkg::BCAD_TMO_SERR_BIT] = q.ctrl.tmo_serr;
  end

  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign wr_hit = {q.aw_addr[31:2], 2'h0} == bcad_pkg::BCAD_CTRL_ADDR;
  assign rd_hit = {araddr[31:2], 2'h0} == bcad_pkg::BCAD_CTRL_ADDR;

  // Next state: bus slave, control fields, abort handling and error signalling.
  always_comb begin
    d = q;
    d.serr = 1'b0;
    d.ma_read_ones = 1'b0;
    d.ma_write_drop = 1'b0;
    d.ma_target_abort = 1'b0;
    d.ma_read_data = '0;
    // Address and data are taken independently, in either order.
    if (awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    // A write completes once both halves are held.
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_hit ? bcad_pkg::BCAD_RESP_OKAY : bcad_pkg::BCAD_RESP_SLVERR;
      if (wr_hit && q.w_strb[bcad_pkg::BCAD_LANE_LO]) begin
        d.ctrl.ma_mode = q.w_data[bcad_pkg::BCAD_MA_MODE_BIT];
        d.ctrl.sec_rst = q.w_data[bcad_pkg::BCAD_SEC_RST_BIT];
        d.ctrl.fb2b = q.w_data[bcad_pkg::BCAD_FB2B_BIT];
      end
      if (wr_hit && q.w_strb[bcad_pkg::BCAD_LANE_HI]) begin
        d.ctrl.pri_short = q.w_data[bcad_pkg::BCAD_PRI_LEN_BIT];
        d.ctrl.sec_short = q.w_data[bcad_pkg::BCAD_SEC_LEN_BIT];
        d.ctrl.tmo_serr = q.w_data[bcad_pkg::BCAD_TMO_SERR_BIT];
        if (q.w_data[bcad_pkg::BCAD_TMO_STAT_BIT]) begin
          d.ctrl.tmo_stat = 1'b0;
        end
      end
    end
    // Expiry sets the status after any clear, so the set wins.
    if (pri_exp || sec_exp) begin
      d.ctrl.tmo_stat = 1'b1;
      d.serr = q.ctrl.tmo_serr;
    end
    d.pri_discard = pri_exp;
    d.sec_discard = sec_exp;
    // Secondary master abort: hide it or report it.
    if (ma.valid) begin
      if (!q.ctrl.ma_mode) begin
        d.ma_read_ones = ma.is_read;
        d.ma_write_drop = !ma.is_read;
        d.ma_read_data = ma.is_read ? bcad_pkg::BCAD_ALL_ONES : '0;
      end else if (ma.ta_possible) begin
        d.ma_target_abort = 1'b1;
      end else if (serr_enable) begin
        d.serr = 1'b1;
      end
    end
    // Read channel answers one cycle after the address is taken.
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_hit ? ctrl_word : '0;
      d.rresp = rd_hit ? bcad_pkg::BCAD_RESP_OKAY : bcad_pkg::BCAD_RESP_SLVERR;
    end
    d.awready = !d.aw_got;
    d.wready = !d.w_got;
    d.arready = !d.rvalid;
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= bcad_pkg::BCAD_TOP_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs, each straight from the state register.
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign primary_system_error_out = q.serr;
  assign sec_reset_force = q.ctrl.sec_rst;
  assign fast_b2b_allow = q.ctrl.fb2b;
  assign pri_discard = q.pri_discard;
  assign sec_discard = q.sec_discard;
  assign ma_read_ones = q.ma_read_ones;
  assign ma_write_drop = q.ma_write_drop;
  assign ma_target_abort = q.ma_target_abort;
  assign ma_read_data = q.ma_read_data;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_ma_hide_read: assert property (ma.valid && ma.is_read && !q.ctrl.ma_mode
      |=> ma_read_ones && ma_read_data == bcad_pkg::BCAD_ALL_ONES && !ma_target_abort)
    else $error("Hidden master abort read did not return all ones.");

  chk_ma_report_ta: assert property (ma.valid && q.ctrl.ma_mode && ma.ta_possible
      |=> ma_target_abort && !ma_read_ones && !ma_write_drop)
    else $error("Reported master abort did not signal target abort.");

  chk_sec_reset_write: assert property (wr_fire && wr_hit && q.w_strb[bcad_pkg::BCAD_LANE_LO]
      |=> sec_reset_force == $past(q.w_data[bcad_pkg::BCAD_SEC_RST_BIT]))
    else $error("Secondary reset output does not follow its control bit.");

  chk_fb2b_reset: assert property ($rose(aresetn) |-> !fast_b2b_allow && !sec_reset_force)
    else $error("Fast back-to-back allowed straight after reset.");

  chk_tmo_set_wins: assert property (pri_exp || sec_exp |=> q.ctrl.tmo_stat)
    else $error("Timeout status missed a discard timer expiry.");

  chk_serr_on_expiry: assert property ((pri_exp || sec_exp) && q.ctrl.tmo_serr |=> primary_system_error_out)
    else $error("Expiry with system error enabled did not assert the output.");

  chk_serr_quiet: assert property (!q.ctrl.tmo_serr && !ma.valid |=> !primary_system_error_out)
    else $error("System error asserted by expiry while disabled.");

  chk_reserved_zero: assert property (rvalid |-> rdata[31:28] == 4'h0 && rdata[20:0] == 21'h0)
    else $error("Reserved bits of the control word read non-zero.");

  chk_discard_drop: assert property (pri_exp |=> pri_discard ##1 !pri_discard)
    else $error("Primary expiry did not discard the queued completion once.");

endmodule

// ---- tb/bcad_far_side.sv ----
`timescale 1ns/1ps
// Bridge logic on the far side: retried initiators and secondary master aborts.
module bcad_far_side (
  input wire logic aclk,
  output bcad_pkg::bcad_dt_evt_t pri_dt,
  output bcad_pkg::bcad_dt_evt_t sec_dt,
  output bcad_pkg::bcad_ma_evt_t ma
);
  // All event lines are quiet from time zero.
  initial begin
    pri_dt = '0;
    sec_dt = '0;
    ma = '0;
  end

  // One-cycle delayed transaction pulse on the chosen sides; rep marks a repeated request.
  task automatic dt_pulse(input bit p, input bit s, input bit rep);
    @(posedge aclk);
    pri_dt <= p ? {~rep, rep} : 2'h0;
    sec_dt <= s ? {~rep, rep} : 2'h0;
    @(posedge aclk);
    pri_dt <= '0;
    sec_dt <= '0;
  endtask

  // A prompt initiator repeats its request gap plus two cycles after the retry.
  task automatic retry(input bit p, input bit s, input int gap);
    dt_pulse(p, s, 1'b0);
    repeat (gap) @(posedge aclk);
    dt_pulse(p, s, 1'b1);
  endtask

  // One master abort seen on the secondary bus.
  task automatic abort(input bit rd, input bit ta);
    @(posedge aclk);
    ma <= {1'b1, rd, ta};
    @(posedge aclk);
    ma <= '0;
  endtask
endmodule

// ---- tb/test_bcad_top.sv ----
`timescale 1ns/1ps
// Register bus, abort and discard timer checks of the bridge control block.
module test_bcad_top;
  localparam int LONG = 40;
  localparam int SHORT = 8;
  localparam logic [31:0] A = bcad_pkg::BCAD_CTRL_ADDR;
  localparam logic [1:0] OK = bcad_pkg::BCAD_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, ma_read_data, ma_dat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic serr_enable, serr, sec_reset_force, fast_b2b_allow, pri_discard, sec_discard;
  logic ma_read_ones, ma_write_drop, ma_target_abort;
  bcad_pkg::bcad_dt_evt_t pri_dt, sec_dt;
  bcad_pkg::bcad_ma_evt_t ma;
  int fails = 0, checked = 0, cyc = 0, pq = 0, sq = 0, pd = 0, sd = 0, st = 0;
  int n_pd = 0, n_sd = 0, n_serr = 0, n_ta = 0, n_one = 0, n_drop = 0;

  bcad_top #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) u_bcad_top (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pri_dt(pri_dt),
    .sec_dt(sec_dt), .ma(ma), .serr_enable(serr_enable), .primary_system_error_out(serr),
    .sec_reset_force(sec_reset_force), .fast_b2b_allow(fast_b2b_allow), .pri_discard(pri_discard),
    .sec_discard(sec_discard), .ma_read_ones(ma_read_ones), .ma_write_drop(ma_write_drop),
    .ma_target_abort(ma_target_abort), .ma_read_data(ma_read_data));
  bcad_far_side u_bcad_far_side (.aclk(aclk), .pri_dt(pri_dt), .sec_dt(sec_dt), .ma(ma));

  // The clock toggles every half period of 12.5 ns.
  always #12.5 aclk = ~aclk;

  // Notes the cycle or count of each queued event and output pulse.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pri_dt.queued) pq <= cyc;
    if (sec_dt.queued) sq <= cyc;
    if (pri_discard) begin
      pd <= cyc;
      n_pd <= n_pd + 1;
    end
    if (sec_discard) begin
      sd <= cyc;
      n_sd <= n_sd + 1;
    end
    if (serr) begin
      st <= cyc;
      n_serr <= n_serr + 1;
    end
    if (ma_target_abort) n_ta <= n_ta + 1;
    if (ma_write_drop) n_drop <= n_drop + 1;
    if (ma_read_ones) begin
      n_one <= n_one + 1;
      ma_dat <= ma_read_data;
    end
  end

  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Write one word; each channel is released at the edge that takes it.
  task automatic chk_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready) aw = 1;
      if (wready) w = 1;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    cmp_word("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  // Read one word and compare data and response.
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    cmp_word("rdata", ed, rdata);
    cmp_word("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (3000) @(posedge aclk);
    fails++;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, serr_enable} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(A, 32'h0000_0000, OK);
    cmp_bit("sec_reset_force", 1'b0, sec_reset_force);
    cmp_bit("fast_b2b_allow", 1'b0, fast_b2b_allow);
    chk_wr(A, 32'hFFFF_FFFF, 4'hF, OK);
    chk_rd(A, 32'h0BE0_0000, OK);
    cmp_bit("sec_reset_force", 1'b1, sec_reset_force);
    cmp_bit("fast_b2b_allow", 1'b1, fast_b2b_allow);
    chk_rd(32'h0000_0040, 32'h0000_0000, bcad_pkg::BCAD_RESP_SLVERR);
    chk_wr(32'h0000_0040, 32'h0000_0000, 4'hF, bcad_pkg::BCAD_RESP_SLVERR);
    u_bcad_far_side.abort(1'b1, 1'b1);
    serr_enable <= 1'b1;
    u_bcad_far_side.abort(1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    serr_enable <= 1'b0;
    u_bcad_far_side.abort(1'b0, 1'b0);
    repeat (3) @(posedge aclk);
    cmp_word("target aborts", 32'h1, 32'(n_ta));
    cmp_word("abort serr", 32'h1, 32'(n_serr));
    chk_wr(A, 32'h0000_0000, 4'h4, OK);
    cmp_bit("sec_reset_force", 1'b0, sec_reset_force);
    cmp_bit("fast_b2b_allow", 1'b0, fast_b2b_allow);
    serr_enable <= 1'b1;
    u_bcad_far_side.abort(1'b1, 1'b1);
    u_bcad_far_side.abort(1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    cmp_word("read ones", 32'h1, 32'(n_one));
    cmp_word("read data", 32'hFFFF_FFFF, ma_dat);
    cmp_word("write drops", 32'h1, 32'(n_drop));
    cmp_word("hidden ta", 32'h1, 32'(n_ta));
    cmp_word("hidden serr", 32'h1, 32'(n_serr));
    u_bcad_far_side.dt_pulse(1'b1, 1'b1, 1'b0);
    repeat (LONG) @(posedge aclk);
    cmp_bit("pri short", 1'b1, (pd - pq) inside {[SHORT + 1 : SHORT + 2]});
    cmp_bit("sec short", 1'b1, (sd - sq) inside {[SHORT + 1 : SHORT + 2]});
    cmp_bit("serr at expiry", 1'b1, st == pd);
    cmp_word("expiry serr", 32'h2, 32'(n_serr));
    cmp_word("discards", 32'h2, 32'(n_pd + n_sd));
    chk_rd(A, 32'h0F00_0000, OK);
    chk_wr(A, 32'h0F00_0000, 4'h8, OK);
    chk_rd(A, 32'h0B00_0000, OK);
    u_bcad_far_side.retry(1'b1, 1'b1, 4);
    repeat (LONG) @(posedge aclk);
    cmp_word("repeated no discard", 32'h2, 32'(n_pd + n_sd));
    // A status clear is timed to land in the very cycle of a short primary expiry; the set must win.
    u_bcad_far_side.dt_pulse(1'b1, 1'b0, 1'b0);
    repeat (SHORT - 2) @(posedge aclk);
    chk_wr(A, 32'h0F00_0000, 4'h8, OK);
    chk_rd(A, 32'h0F00_0000, OK);
    cmp_word("set wins discard", 32'h3, 32'(n_pd + n_sd));
    cmp_word("set wins serr", 32'h3, 32'(n_serr));
    chk_wr(A, 32'h0000_0000, 4'h8, OK);
    u_bcad_far_side.dt_pulse(1'b1, 1'b1, 1'b0);
    repeat (LONG + 10) @(posedge aclk);
    cmp_bit("pri long", 1'b1, (pd - pq) inside {[LONG + 1 : LONG + 2]});
    cmp_bit("sec long", 1'b1, (sd - sq) inside {[LONG + 1 : LONG + 2]});
    cmp_word("no expiry serr", 32'h3, 32'(n_serr));
    chk_rd(A, 32'h0400_0000, OK);
    tally_and_finish;
  end
endmodule
